// File: shared/scr_pkg.sv
// Constants, register map and types of the serial configuration and readback port
package scr_pkg;

	// ==========================================================
	// Word layout
	localparam int SCR_ADDR_W   = 5;
	localparam int SCR_DATA_W   = 27;
	localparam int SCR_WORD_W   = 32;
	localparam int SCR_NUM_REGS = 32;
	localparam int SCR_NUM_PINS = 5;

	typedef logic [SCR_DATA_W-1:0] scr_data_t;

	typedef struct packed {
		logic [SCR_DATA_W-1:0] data;
		logic [SCR_ADDR_W-1:0] addr;
	} scr_word_s;

	typedef struct packed {
		logic out;
		logic oe;
	} scr_pin_s;

	// ==========================================================
	// Register addresses
	localparam logic [4:0] SCR_REG_GROUP01_DIVIDER_DELAY_CTRL   = 5'h00;
	localparam logic [4:0] SCR_REG_GROUP23_DIVIDER_DELAY_CTRL   = 5'h01;
	localparam logic [4:0] SCR_REG_GROUP45_DIVIDER_DELAY_CTRL   = 5'h02;
	localparam logic [4:0] SCR_REG_GROUP67_DIVIDER_DELAY_CTRL   = 5'h03;
	localparam logic [4:0] SCR_REG_GROUP89_DIVIDER_DELAY_CTRL   = 5'h04;
	localparam logic [4:0] SCR_REG_GROUP1011_DIVIDER_DELAY_CTRL = 5'h05;
	localparam logic [4:0] SCR_REG_OUTPUT_FORMAT_A              = 5'h06;
	localparam logic [4:0] SCR_REG_OUTPUT_FORMAT_B              = 5'h07;
	localparam logic [4:0] SCR_REG_OUTPUT_FORMAT_C              = 5'h08;
	localparam logic [4:0] SCR_REG_FIXED_REQUIRED_WORD          = 5'h09;
	localparam logic [4:0] SCR_REG_OSC_OUT_FEEDBACK_CTRL        = 5'h0a;
	localparam logic [4:0] SCR_REG_PART_MODE_SYNC_CTRL          = 5'h0b;
	localparam logic [4:0] SCR_REG_LOCK_PIN_HOLDOVER_CTRL       = 5'h0c;
	localparam logic [4:0] SCR_REG_INPUT_SELECT_CTRL            = 5'h0d;
	localparam logic [4:0] SCR_REG_SIGNAL_LOSS_DAC_TRIP_CTRL    = 5'h0e;
	localparam logic [4:0] SCR_REG_MANUAL_DAC_HOLDOVER_CTRL     = 5'h0f;
	localparam logic [4:0] SCR_REG_DAC_COUNT_READBACK           = 5'h17;
	localparam logic [4:0] SCR_REG_READBACK_LOCK_CTRL           = 5'h1f;

	// ==========================================================
	// Field positions inside the 27-bit data part
	localparam int SCR_SOFT_RESET_BIT    = 12;
	localparam int SCR_RB_ADDR_LSB       = 11;
	localparam int SCR_RB_LATCH_MODE_BIT = 16;
	localparam int SCR_WRITE_LOCK_BIT    = 0;
	localparam int SCR_RB_LE_ALIAS_BIT   = 16;
	localparam int SCR_DAC_LSB           = 14;
	localparam int SCR_DAC_W             = 10;

	// ==========================================================
	// Status pins: 0 lock, 1 holdover, 2 input0, 3 input1, 4 sync
	localparam int SCR_PIN_MUX_REG  [SCR_NUM_PINS] = '{12, 13, 13, 13, 11};
	localparam int SCR_PIN_MUX_LSB  [SCR_NUM_PINS] = '{22, 22, 7, 15, 13};
	localparam int SCR_PIN_MUX_W    [SCR_NUM_PINS] = '{5, 5, 3, 3, 2};
	localparam int SCR_PIN_TYPE_REG [SCR_NUM_PINS] = '{12, 13, 13, 14, 11};
	localparam int SCR_PIN_TYPE_LSB [SCR_NUM_PINS] = '{19, 19, 11, 19, 7};
	localparam int SCR_PIN_RB_CODE  [SCR_NUM_PINS] = '{7, 7, 6, 6, 3};
	localparam logic [2:0] SCR_TYPE_PUSH_PULL     = 3'h3;
	localparam logic [2:0] SCR_TYPE_PUSH_PULL_INV = 3'h4;

	// ==========================================================
	// Power-on and soft reset contents (data parts)
	localparam scr_data_t SCR_REG_DEFAULTS [SCR_NUM_REGS] = '{
		0: 27'h4000019, 1: 27'h4000019, 2: 27'h4000019, 3: 27'h2000001,
		4: 27'h0000019, 5: 27'h4000019, 7: 27'h0400000, 10: 27'h40a0010,
		11: 27'h02c0880, 12: 27'h0d8000c, 13: 27'h1d80000, default: 27'h0000000
	};

endpackage : scr_pkg

// File: hdl/scr_config_port.sv
// Three-wire serial configuration port with register store and serial readback
`timescale 1ns/1ps
// Overview of operation
// - Words are 32 bits, 5-bit address low, 27-bit data high, MSB first.
// - Data sampled on rising serial clock with latch low; latch pulse writes word.
// - Register 0 with soft reset bit restores defaults, ignoring the word's other bits.
// - Any of five status pins gives readback when muxed to readback and push-pull.
// - After power-on the holdover pin acts as the readback output.
// - Readback returns the register named by the readback address, even same write.
// - After a write each rising serial clock presents a new readback bit.
// - Readback is MSB first and complete after 27 serial clocks.
// - Clocks beyond the twenty-seventh give undefined readback data.
// - Registers read back at their own address, except readback latch mode bit.
// - The tuning DAC count is read only and only visible in readback.
// - Readback returns data bits only, shifted down by the address width.
// - Reserved bits read back undefined.
module scr_config_port (
	input  wire logic                                          CLOCK_I,
	input  wire logic                                          RESET_I,
	input  wire logic                                          SERIAL_CLOCK_PIN_I,
	input  wire logic                                          SERIAL_DATA_PIN_I,
	input  wire logic                                          LATCH_ENABLE_PIN_I,
	input  wire logic [scr_pkg::SCR_DAC_W-1:0]                 TUNING_DAC_COUNT_I,
	output scr_pkg::scr_pin_s [scr_pkg::SCR_NUM_PINS-1:0]      STATUS_PINS_O
);
	import scr_pkg::*;

	// ==========================================================
	// Pin synchronisers and edge detection
	logic [2:0]          sclk_q, sclk_d;
	logic [1:0]          sdata_q, sdata_d;
	logic [2:0]          le_q, le_d;
	logic                sclk_rise;
	logic                le_rise;
	logic                le_fall;

	always_comb begin
		sclk_d  = {sclk_q[1:0], SERIAL_CLOCK_PIN_I};
		sdata_d = {sdata_q[0], SERIAL_DATA_PIN_I};
		le_d    = {le_q[1:0], LATCH_ENABLE_PIN_I};
	end

	always_ff @(posedge CLOCK_I) begin
		if (RESET_I) begin
			sclk_q  <= 3'h0;
			sdata_q <= 2'h0;
			le_q    <= 3'h0;
		end else begin
			sclk_q  <= sclk_d;
			sdata_q <= sdata_d;
			le_q    <= le_d;
		end
	end

	// Stage 0 of each chain feeds only stage 1; edges compare stages 1 and 2
	assign sclk_rise = sclk_q[1] & ~sclk_q[2];
	assign le_rise   = le_q[1] & ~le_q[2];
	assign le_fall   = ~le_q[1] & le_q[2];

	// ==========================================================
	// Incoming shift register
	logic [SCR_WORD_W-1:0] shift_q, shift_d;
	scr_word_s             in_word;

	always_comb begin
		shift_d = shift_q;
		if (sclk_rise && !le_q[1]) begin
			shift_d = {shift_q[SCR_WORD_W-2:0], sdata_q[1]};
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RESET_I) begin
			shift_q <= 32'h0;
		end else begin
			shift_q <= shift_d;
		end
	end

	assign in_word = scr_word_s'(shift_q);

	// ==========================================================
	// Configuration store
	scr_data_t           cfg_q [SCR_NUM_REGS];
	scr_data_t           cfg_d [SCR_NUM_REGS];
	logic                wr_ok;
	logic                rb_mode;
	logic [4:0]          rb_addr;

	assign rb_mode = cfg_q[SCR_REG_READBACK_LOCK_CTRL][SCR_RB_LATCH_MODE_BIT];
	assign rb_addr = cfg_q[SCR_REG_READBACK_LOCK_CTRL][SCR_RB_ADDR_LSB +: SCR_ADDR_W];
	// Once locked only the lock register itself stays writable, so it can be released
	assign wr_ok   = !cfg_q[SCR_REG_READBACK_LOCK_CTRL][SCR_WRITE_LOCK_BIT]
		|| (in_word.addr == SCR_REG_READBACK_LOCK_CTRL);

	always_comb begin
		cfg_d = cfg_q;
		if (le_rise && wr_ok) begin
			if (in_word.addr == SCR_REG_GROUP01_DIVIDER_DELAY_CTRL && in_word.data[SCR_SOFT_RESET_BIT]) begin
				cfg_d = SCR_REG_DEFAULTS;
			end else if (in_word.addr != SCR_REG_DAC_COUNT_READBACK) begin
				cfg_d[in_word.addr] = in_word.data;
			end
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RESET_I) begin
			cfg_q <= SCR_REG_DEFAULTS;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// ==========================================================
	// Readback capture and shift-out
	logic [SCR_DATA_W-1:0] rb_q, rb_d;
	logic [SCR_DATA_W-1:0] rb_view;
	logic                  rb_bit_q, rb_bit_d;
	logic                  cap_pend_q, cap_pend_d;
	logic                  capture;

	always_comb begin
		rb_view = cfg_q[rb_addr];
		if (rb_addr == SCR_REG_LOCK_PIN_HOLDOVER_CTRL) begin
			rb_view[SCR_RB_LE_ALIAS_BIT] = rb_mode;
		end
		if (rb_addr == SCR_REG_DAC_COUNT_READBACK) begin
			rb_view = '0;
			rb_view[SCR_DAC_LSB +: SCR_DAC_W] = TUNING_DAC_COUNT_I;
		end
	end

	// With the latch mode bit set, capture waits one cycle after the rising latch so a same-word address change is seen; otherwise it is on the falling latch
	assign capture = (cap_pend_q && rb_mode) || (le_fall && !rb_mode);

	always_comb begin
		cap_pend_d = le_rise;
		rb_d       = rb_q;
		rb_bit_d   = rb_bit_q;
		if (capture) begin
			rb_d = rb_view;
		end else if (sclk_rise && (!le_q[1] || rb_mode)) begin
			rb_bit_d = rb_q[SCR_DATA_W-1];
			rb_d     = {rb_q[SCR_DATA_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RESET_I) begin
			rb_q       <= 27'h0;
			rb_bit_q   <= 1'b0;
			cap_pend_q <= 1'b0;
		end else begin
			rb_q       <= rb_d;
			rb_bit_q   <= rb_bit_d;
			cap_pend_q <= cap_pend_d;
		end
	end

	// ==========================================================
	// Status pin routing
	logic [4:0]  pin_mux  [SCR_NUM_PINS];
	logic [2:0]  pin_type [SCR_NUM_PINS];
	scr_pin_s [SCR_NUM_PINS-1:0] pins_d;

	for (genvar i = 0; i < SCR_NUM_PINS; i++) begin : g_pin
		assign pin_mux[i]  = 5'((cfg_q[SCR_PIN_MUX_REG[i]] >> SCR_PIN_MUX_LSB[i])
			& ((27'h1 << SCR_PIN_MUX_W[i]) - 27'h1));
		assign pin_type[i] = 3'(cfg_q[SCR_PIN_TYPE_REG[i]] >> SCR_PIN_TYPE_LSB[i]);
		// Sources other than readback are outside this block and read as constant low
		assign pins_d[i].out = ((pin_mux[i] == 5'(SCR_PIN_RB_CODE[i])) & rb_bit_q)
			^ (pin_type[i] == SCR_TYPE_PUSH_PULL_INV);
		assign pins_d[i].oe  = (pin_type[i] == SCR_TYPE_PUSH_PULL)
			|| (pin_type[i] == SCR_TYPE_PUSH_PULL_INV);
	end

	always_ff @(posedge CLOCK_I) begin
		if (RESET_I) begin
			STATUS_PINS_O <= '0;
		end else begin
			STATUS_PINS_O <= pins_d;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (RESET_I);

	shift_in_a: assert property (sclk_rise && !le_q[1] |=> shift_q[0] == $past(sdata_q[1]))
		else $error("serial data bit not shifted in");

	word_write_a: assert property (le_rise && wr_ok && in_word.addr != SCR_REG_DAC_COUNT_READBACK
		&& !(in_word.addr == SCR_REG_GROUP01_DIVIDER_DELAY_CTRL && in_word.data[SCR_SOFT_RESET_BIT])
		|=> cfg_q[$past(in_word.addr)] == $past(in_word.data))
		else $error("latched word not stored at its address");

	soft_reset_a: assert property (le_rise && wr_ok && in_word.addr == SCR_REG_GROUP01_DIVIDER_DELAY_CTRL
		&& in_word.data[SCR_SOFT_RESET_BIT] |=> cfg_q[0] == SCR_REG_DEFAULTS[0]
		&& cfg_q[13] == SCR_REG_DEFAULTS[13] && cfg_q[31] == SCR_REG_DEFAULTS[31])
		else $error("soft reset did not restore defaults");

	dac_readonly_a: assert property (le_rise && in_word.addr == SCR_REG_DAC_COUNT_READBACK
		|=> $stable(cfg_q[23]))
		else $error("read-only count location was written");

	rb_capture_a: assert property (le_fall && !rb_mode && rb_addr != SCR_REG_DAC_COUNT_READBACK
		&& rb_addr != SCR_REG_LOCK_PIN_HOLDOVER_CTRL |=> rb_q == cfg_q[$past(rb_addr)])
		else $error("selected register not captured at latch fall");

	rb_alias_a: assert property (capture && rb_addr == SCR_REG_LOCK_PIN_HOLDOVER_CTRL
		|=> rb_q[SCR_RB_LE_ALIAS_BIT] == $past(rb_mode))
		else $error("latch mode bit missing from its readback location");

	dac_view_a: assert property (capture && rb_addr == SCR_REG_DAC_COUNT_READBACK
		|=> rb_q[SCR_DAC_LSB +: SCR_DAC_W] == $past(TUNING_DAC_COUNT_I))
		else $error("tuning count not returned in readback");

	rb_shift_a: assert property (!capture && sclk_rise && !le_q[1]
		|=> rb_bit_q == $past(rb_q[26]) ##1 STATUS_PINS_O[1].out == $past(rb_bit_q)
		|| pin_mux[1] != 5'h7 || pin_type[1] != SCR_TYPE_PUSH_PULL)
		else $error("readback bit not presented on rising serial clock");

	por_holdover_a: assert property ($fell(RESET_I) |=> STATUS_PINS_O[1].oe)
		else $error("holdover pin not driving after reset");

	lock_debug_a: assert property (pin_mux[0] == 5'h0 && pin_type[0] == SCR_TYPE_PUSH_PULL_INV
		|=> STATUS_PINS_O[0].out && STATUS_PINS_O[0].oe)
		else $error("inverted constant-low lock pin not high");

	write_cov_c:  cover property (le_rise && wr_ok);
	reset_cov_c:  cover property (le_rise && in_word.addr == 5'h0 && in_word.data[SCR_SOFT_RESET_BIT]);
	cap_mode1_c:  cover property (cap_pend_q && rb_mode);
	cap_mode0_c:  cover property (le_fall && !rb_mode ##[1:400] sclk_rise);

endmodule : scr_config_port

// File: verif/scr_host_model.sv
// Host-side model of the three-wire configuration and readback link
`timescale 1ns/1ps
module scr_host_model (
	input  wire logic                                            CLOCK_I,
	input  wire scr_pkg::scr_pin_s [scr_pkg::SCR_NUM_PINS-1:0]  STATUS_PINS_I,
	output logic                                                 SERIAL_CLOCK_PIN_O,
	output logic                                                 SERIAL_DATA_PIN_O,
	output logic                                                 LATCH_ENABLE_PIN_O
);
	import scr_pkg::*;

	initial begin
		SERIAL_CLOCK_PIN_O = 1'b0;
		SERIAL_DATA_PIN_O  = 1'b0;
		LATCH_ENABLE_PIN_O = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge CLOCK_I);
	endtask : wait_clk

	// ==========================================================
	// Write cycle
	task automatic write_word(input scr_word_s word, input logic hold_latch);
		// Align the first data change with a rising system clock edge
		wait_clk(1);
		for (int i = SCR_WORD_W-1; i >= 0; i--) begin
			SERIAL_DATA_PIN_O  <= word[i];
			wait_clk(4);
			SERIAL_CLOCK_PIN_O <= 1'b1;
			wait_clk(4);
			SERIAL_CLOCK_PIN_O <= 1'b0;
		end
		// Released data line inverts so a stale bit is never taken for a live one
		SERIAL_DATA_PIN_O  <= ~word[0];
		wait_clk(4);
		LATCH_ENABLE_PIN_O <= 1'b1;
		wait_clk(4);
		LATCH_ENABLE_PIN_O <= hold_latch;
		wait_clk(4);
	endtask : write_word

	// ==========================================================
	// Read cycle
	// Sampled late in the low phase: the pin lags the serial clock by the synchroniser
	task automatic read_word(output logic [SCR_NUM_PINS-1:0][SCR_DATA_W-1:0] val);
		for (int i = SCR_DATA_W-1; i >= 0; i--) begin
			SERIAL_CLOCK_PIN_O <= 1'b1;
			wait_clk(4);
			SERIAL_CLOCK_PIN_O <= 1'b0;
			wait_clk(3);
			@(negedge CLOCK_I);
			for (int p = 0; p < SCR_NUM_PINS; p++)
				val[p][i] = STATUS_PINS_I[p].out;
			wait_clk(1);
		end
	endtask : read_word

	task automatic drop_latch();
		LATCH_ENABLE_PIN_O <= 1'b0;
		wait_clk(4);
	endtask : drop_latch

endmodule : scr_host_model

// File: verif/scr_config_port_test.sv
// Self-checking testbench of the serial configuration and readback port
`timescale 1ns/1ps
module scr_config_port_test;
	import scr_pkg::*;

	logic                                     clock_i   = 1'b0;
	logic                                     reset_i   = 1'b1;
	logic                                     sclk;
	logic                                     sdata;
	logic                                     latch;
	logic [SCR_DAC_W-1:0]                     dac_count = 10'h2a5;
	scr_pin_s [SCR_NUM_PINS-1:0]              pins;
	logic [SCR_NUM_PINS-1:0][SCR_DATA_W-1:0] rb;
	int                                       bad_count = 0;
	int                                       checked   = 0;
	int                                       cycles    = 0;
	// Alternating pattern that the fixed register must hold
	localparam scr_data_t                     FIXED_WORD_DATA = 27'h2aaaaaa;

	always #12.5 clock_i = ~clock_i;

	scr_config_port scr_config_port_inst (.CLOCK_I(clock_i), .RESET_I(reset_i), .SERIAL_CLOCK_PIN_I(sclk),
		.SERIAL_DATA_PIN_I(sdata), .LATCH_ENABLE_PIN_I(latch), .TUNING_DAC_COUNT_I(dac_count),
		.STATUS_PINS_O(pins));

	scr_host_model scr_host_model_inst (.CLOCK_I(clock_i), .STATUS_PINS_I(pins), .SERIAL_CLOCK_PIN_O(sclk),
		.SERIAL_DATA_PIN_O(sdata), .LATCH_ENABLE_PIN_O(latch));

	// ==========================================================
	// Compare and bus helpers
	task automatic check_data(input scr_data_t got, input scr_data_t exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_data

	task automatic check_pin(input scr_pin_s got, input scr_pin_s exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_pin

	task automatic write(input logic [4:0] addr, input scr_data_t data);
		scr_host_model_inst.write_word({data, addr}, 1'b0);
	endtask : write

	// Selecting the address and reading in the same operation
	task automatic read_reg(input logic [4:0] addr);
		write(SCR_REG_READBACK_LOCK_CTRL, scr_data_t'(addr) << SCR_RB_ADDR_LSB);
		scr_host_model_inst.read_word(rb);
	endtask : read_reg

	// ==========================================================
	// Scenarios
	task automatic t_defaults();
		@(negedge clock_i);
		check_pin(pins[1], 2'b01);
		check_pin(pins[0], 2'b01);
		check_pin(pins[2], 2'b00);
		check_pin(pins[3], 2'b00);
		check_pin(pins[4], 2'b00);
	endtask : t_defaults

	// Start-up order: soft reset first, register 0 again with reset clear, fixed word, 31 last
	task automatic t_init_seq();
		write(SCR_REG_GROUP01_DIVIDER_DELAY_CTRL, scr_data_t'(1) << SCR_SOFT_RESET_BIT);
		write(SCR_REG_GROUP01_DIVIDER_DELAY_CTRL, SCR_REG_DEFAULTS[0]);
		write(SCR_REG_FIXED_REQUIRED_WORD, FIXED_WORD_DATA);
		read_reg(SCR_REG_FIXED_REQUIRED_WORD);
		check_data(rb[1], FIXED_WORD_DATA);
	endtask : t_init_seq

	task automatic t_plain();
		write(SCR_REG_GROUP67_DIVIDER_DELAY_CTRL, 27'h5a5a5a5);
		read_reg(5'h03);
		check_data(rb[1], 27'h5a5a5a5);
	endtask : t_plain

	task automatic t_soft_reset();
		write(SCR_REG_GROUP01_DIVIDER_DELAY_CTRL, 27'h7ffffff);
		read_reg(5'h03);
		check_data(rb[1], SCR_REG_DEFAULTS[3]);
	endtask : t_soft_reset

	task automatic t_dac();
		write(SCR_REG_DAC_COUNT_READBACK, 27'h7ffffff);
		read_reg(SCR_REG_DAC_COUNT_READBACK);
		check_data(rb[1], scr_data_t'(dac_count) << SCR_DAC_LSB);
		dac_count <= 10'h15a;
		read_reg(SCR_REG_DAC_COUNT_READBACK);
		check_data(rb[1], scr_data_t'(10'h15a) << SCR_DAC_LSB);
	endtask : t_dac

	task automatic t_latch_mode();
		scr_host_model_inst.write_word({27'h0016000, SCR_REG_READBACK_LOCK_CTRL}, 1'b1);
		scr_host_model_inst.read_word(rb);
		scr_host_model_inst.drop_latch();
		check_data(rb[1], SCR_REG_DEFAULTS[12] | 27'h0010000);
		write(SCR_REG_READBACK_LOCK_CTRL, 27'h0000000);
	endtask : t_latch_mode

	task automatic t_pins();
		write(SCR_REG_LOCK_PIN_HOLDOVER_CTRL, 27'h0180000);
		@(negedge clock_i);
		check_pin(pins[0], 2'b01);
		write(SCR_REG_LOCK_PIN_HOLDOVER_CTRL, 27'h0200000);
		@(negedge clock_i);
		check_pin(pins[0], 2'b11);
		write(SCR_REG_PART_MODE_SYNC_CTRL, 27'h0006180);
		write(SCR_REG_INPUT_SELECT_CTRL, 27'h1db1b00);
		write(SCR_REG_SIGNAL_LOSS_DAC_TRIP_CTRL, 27'h0180000);
		read_reg(5'h0d);
		check_data(rb[1], 27'h1db1b00);
		check_data(rb[2], 27'h1db1b00);
		check_data(rb[3], 27'h1db1b00);
		check_data(rb[4], 27'h1db1b00);
	endtask : t_pins

	// ==========================================================
	// Verdict and run control
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			bad_count++;
			results();
		end
	end

	initial begin
		repeat (16) @(posedge clock_i);
		reset_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		t_defaults();
		t_init_seq();
		t_plain();
		t_soft_reset();
		t_dac();
		t_latch_mode();
		t_pins();
		results();
	end

endmodule : scr_config_port_test
